//--- logic/gtc_regs.svh
/*
 * Register offsets, field positions, reset values and count constants of
 * the general timer. Assumes it is included by bare name from the package
 * and the design modules; it defines macros only.
 */
`ifndef GTC_REGS_SVH
`define GTC_REGS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define GTC_OFF_CTRL      4'h0
`define GTC_OFF_COUNT     4'h4
`define GTC_OFF_RELOAD    4'h8
`define GTC_OFF_STATUS    4'hC

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define GTC_CTRL_EN       0
`define GTC_CTRL_MODE_LO  1
`define GTC_CTRL_MODE_HI  4
`define GTC_CTRL_PS_LO    5
`define GTC_CTRL_PS_HI    7
`define GTC_CTRL_POL      8
`define GTC_CTRL_OEN      9
`define GTC_CTRL_W        10

// ----------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------
`define GTC_ST_RUN        0
`define GTC_ST_OUT        1
`define GTC_ST_ARMED      2

// ----------------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------------
`define GTC_CTRL_RST      10'h000
`define GTC_COUNT_RST     16'h0001
`define GTC_RELOAD_RST    16'h0000
`define GTC_RESTART       16'h0001
`define GTC_PS_MAX_LOG2   3'h7

// ----------------------------------------------------------------------
// Bus answers
// ----------------------------------------------------------------------
`define GTC_RESP_OKAY     2'h0
`define GTC_RESP_SLVERR   2'h2

`endif

//--- logic/gtc_pkg.sv
/*
 * Types of the general timer: mode codes and trigger states.
 * Assumes the register header sits in the include path.
 */
`include "gtc_regs.svh"

package gtc_pkg;

   // ----------------------------------------------------------------------
   // Mode select codes, one per operating mode
   // ----------------------------------------------------------------------
   typedef enum logic [3:0] {
      GTC_ONE_SHOT  = 4'h0,
      GTC_TRIG_SHOT = 4'h1,
      GTC_CONT      = 4'h2,
      GTC_COUNTER   = 4'h3,
      GTC_COMP_CNT  = 4'h4,
      GTC_PWM_ONE   = 4'h5,
      GTC_PWM_TWO   = 4'h6,
      GTC_CAP_RST   = 4'h7,
      GTC_CAP_CMP   = 4'h8,
      GTC_COMPARE   = 4'h9,
      GTC_GATED     = 4'hA
   } gtc_mode_e;

   // ----------------------------------------------------------------------
   // Triggered one-shot state
   // ----------------------------------------------------------------------
   typedef enum logic {
      GTC_TRG_ARMED = 1'b0,
      GTC_TRG_RUN   = 1'b1
   } gtc_trig_e;

endpackage : gtc_pkg

//--- logic/gtc_edge.sv
/*
 * Two-stage synchroniser followed by an edge detector.
 * Assumes the input is slow against the clock (a quarter of it at most).
 */
`timescale 1ns/1ps

module gtc_edge
   import gtc_pkg::*;
(
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // Raw level and detected edges
   input  wire logic din,
   output logic      rise,
   output logic      fall
);

   logic [1:0] sync_r;    // Synchroniser chain
   logic [1:0] sync_nxt;  // Next chain value
   logic       prev_r;    // Last settled level
   logic       prev_nxt;  // Next settled level

   // ----------------------------------------------------------------------
   // Next values: stage one feeds stage two only
   // ----------------------------------------------------------------------
   always_comb
   begin
      sync_nxt = {sync_r[0], din};
      prev_nxt = sync_r[1];
   end

   // Registers
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         sync_r <= 2'h0;
         prev_r <= 1'b0;
      end
      else
      begin
         sync_r <= sync_nxt;
         prev_r <= prev_nxt;
      end
   end

   // Edges look only at the settled stage and its delayed copy
   assign rise = sync_r[1] & ~prev_r;
   assign fall = ~sync_r[1] & prev_r;

endmodule : gtc_edge

//--- logic/gtc_timer.sv
/*
 * General 16-bit reloadable up-timer with prescaler and AXI4-Lite slave.
 * Assumes timer input and comparator output are slow, external inputs
 * that are synchronised here; one clock, active-high async reset.
 */
// The AXI4-Lite interface to the registers and the register offsets are this design's own decisions.
//
// Contract
// - Mode field selects one of eleven modes; only one-shot, triggered, continuous and both counter modes are built
// - One-shot: at reload irq, count 0001h, stop
// - One-shot output flips for one cycle
// - One-shot timeout is (reload-start+1) times prescale
// - Triggered one-shot waits for polarity-selected input edge
// - Triggered: count, pulse, irq, count 0001h
// - Edges ignored while counting; then re-arm
// - Enable only arms triggered one-shot mode
// - Trigger synchroniser adds two to three cycles
// - Continuous: irq, count 0001h, keep counting
// - Continuous toggles enabled output at reload
// - Start count only affects first pass
// - Continuous period is reload times prescale
// - Counter mode counts input edges, no prescaler
// - Comparator counter counts comparator edges, no prescaler
// - Prescaler divides by 1 to 128
// - Count rolls FFFFh to 0000h
// - Counter modes: irq, 0001h, toggle output
`timescale 1ns/1ps

`include "gtc_regs.svh"

module gtc_timer
   import gtc_pkg::*;
#(
   parameter int ADDR_W = 4
)
(
   // Clock and reset
   input  wire logic              CORE_CLK,
   input  wire logic              RESET,
   // AXI4-Lite write address and data
   input  wire logic [ADDR_W-1:0] S_AXI_AWADDR,
   input  wire logic              S_AXI_AWVALID,
   output logic                   S_AXI_AWREADY,
   input  wire logic [31:0]       S_AXI_WDATA,
   input  wire logic [3:0]        S_AXI_WSTRB,
   input  wire logic              S_AXI_WVALID,
   output logic                   S_AXI_WREADY,
   // AXI4-Lite write response
   output logic [1:0]             S_AXI_BRESP,
   output logic                   S_AXI_BVALID,
   input  wire logic              S_AXI_BREADY,
   // AXI4-Lite read
   input  wire logic [ADDR_W-1:0] S_AXI_ARADDR,
   input  wire logic              S_AXI_ARVALID,
   output logic                   S_AXI_ARREADY,
   output logic [31:0]            S_AXI_RDATA,
   output logic [1:0]             S_AXI_RRESP,
   output logic                   S_AXI_RVALID,
   input  wire logic              S_AXI_RREADY,
   // Timer pins
   input  wire logic              TIMER_IN,
   input  wire logic              COMP_IN,
   output logic                   TIMER_OUT,
   output logic                   TIMER_OUT_EN,
   output logic                   TIMER_IRQ
);

   // ----------------------------------------------------------------------
   // Functions
   // ----------------------------------------------------------------------
   // Byte-lane merge of a 16-bit register
   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] data,
                                           input logic [3:0]  strb);
      logic [15:0] res;
      res = old;
      if (strb[0]) res[7:0] = data[7:0];
      if (strb[1]) res[15:8] = data[15:8];
      return res;
   endfunction : merge16

   // Prescale exponent to terminal count (divide minus one)
   function automatic logic [6:0] div_m1(input logic [2:0] ps);
      logic [7:0] div;
      div = 8'h01 << ps;
      return 7'(div - 8'h01);
   endfunction : div_m1

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   logic [`GTC_CTRL_W-1:0] ctrl_r, ctrl_nxt;       // Control register
   logic [15:0]            cnt_r, cnt_nxt;         // Count register
   logic [15:0]            rld_r, rld_nxt;         // Reload register
   logic [6:0]             presc_r, presc_nxt;     // Prescaler
   gtc_trig_e              trg_r, trg_nxt;         // Triggered state
   logic                   out_r, out_nxt;         // Output level
   logic                   irq_r, irq_nxt;         // Reload pulse
   logic                   awg_r, awg_nxt;         // Write address held
   logic                   wg_r, wg_nxt;           // Write data held
   logic [ADDR_W-1:0]      wa_r, wa_nxt;           // Held write address
   logic [31:0]            wd_r, wd_nxt;           // Held write data
   logic [3:0]             ws_r, ws_nxt;           // Held strobes
   logic                   awrdy_r, awrdy_nxt;     // Address ready
   logic                   wrdy_r, wrdy_nxt;       // Data ready
   logic                   bval_r, bval_nxt;       // Response valid
   logic [1:0]             bresp_r, bresp_nxt;     // Write answer
   logic                   arrdy_r, arrdy_nxt;     // Read address ready
   logic                   rval_r, rval_nxt;       // Read valid
   logic [31:0]            rdat_r, rdat_nxt;       // Read data
   logic [1:0]             rresp_r, rresp_nxt;     // Read answer

   // ----------------------------------------------------------------------
   // Decoded control and events
   // ----------------------------------------------------------------------
   gtc_mode_e   mode;        // Selected mode
   logic        en, pol;     // Enable and output_polarity_select
   logic        tin_rise, tin_fall, cmp_rise, cmp_fall;
   logic        trig_edge;   // Polarity-selected timer input edge
   logic        timed;       // Counting prescaled clocks
   logic        edge_mode;   // Counting input edges
   logic        tick, step, hit;
   logic        shot_mode;   // One-shot style output
   logic        wr_land;     // A bus write updates registers this cycle

   assign mode = gtc_mode_e'(ctrl_r[`GTC_CTRL_MODE_HI:`GTC_CTRL_MODE_LO]);
   assign en   = ctrl_r[`GTC_CTRL_EN];
   assign pol  = ctrl_r[`GTC_CTRL_POL];

   // Both external inputs pass the synchroniser first
   gtc_edge u_tin_edge (
      .clk  (CORE_CLK),
      .rst  (RESET),
      .din  (TIMER_IN),
      .rise (tin_rise),
      .fall (tin_fall)
   );
   gtc_edge u_cmp_edge (
      .clk  (CORE_CLK),
      .rst  (RESET),
      .din  (COMP_IN),
      .rise (cmp_rise),
      .fall (cmp_fall)
   );

   assign trig_edge = pol ? tin_fall : tin_rise;
   // Triggered mode counts only once a trigger has moved it to run
   assign timed = en && (mode == GTC_ONE_SHOT || mode == GTC_CONT ||
                         (mode == GTC_TRIG_SHOT && trg_r == GTC_TRG_RUN));
   assign edge_mode = en && (mode == GTC_COUNTER || mode == GTC_COMP_CNT);
   assign tick = timed && (presc_r == div_m1(ctrl_r[`GTC_CTRL_PS_HI:`GTC_CTRL_PS_LO]));
   // Edge modes bypass the prescaler entirely
   assign step = tick || (edge_mode && ((mode == GTC_COMP_CNT) ?
                 (pol ? cmp_fall : cmp_rise) : trig_edge));
   assign hit  = step && (cnt_r == rld_r);
   assign shot_mode = (mode == GTC_ONE_SHOT) || (mode == GTC_TRIG_SHOT);
   // The response only rises when a write lands, so this marks software updates
   assign wr_land = bval_nxt && !bval_r;

   // ----------------------------------------------------------------------
   // Next values: bus slave and timer
   // ----------------------------------------------------------------------
   always_comb
   begin
      logic do_wr;
      logic wr_ok;
      logic [15:0] ctrl_w;
      do_wr = 1'b0;
      wr_ok = 1'b0;
      ctrl_w = 16'h0000;
      ctrl_nxt = ctrl_r;
      cnt_nxt = cnt_r;
      rld_nxt = rld_r;
      presc_nxt = 7'h00;
      trg_nxt = trg_r;
      out_nxt = out_r;
      irq_nxt = hit;
      awg_nxt = awg_r;
      wg_nxt = wg_r;
      wa_nxt = wa_r;
      wd_nxt = wd_r;
      ws_nxt = ws_r;
      bval_nxt = bval_r;
      bresp_nxt = bresp_r;
      rval_nxt = rval_r;
      rdat_nxt = rdat_r;
      rresp_nxt = rresp_r;

      // Timer: prescaler runs only while timed counting
      if (timed && !tick)
         presc_nxt = presc_r + 7'h01;
      // Count steps and wraps FFFFh to 0000h; reload restarts at 0001h
      if (hit)
         cnt_nxt = `GTC_RESTART;
      else if (step)
         cnt_nxt = cnt_r + 16'h0001;
      // Output: one-cycle flip for one-shot styles, toggle otherwise
      if (shot_mode)
      begin
         if (hit)
            out_nxt = ~out_r;
         else if (irq_r)
            out_nxt = pol;
      end
      else if (hit)
         out_nxt = ~out_r;
      // One-shot disables itself at reload
      if (hit && mode == GTC_ONE_SHOT)
         ctrl_nxt[`GTC_CTRL_EN] = 1'b0;
      // Triggered state: late edges are ignored while running
      if (!en || mode != GTC_TRIG_SHOT)
         trg_nxt = GTC_TRG_ARMED;
      else if (trg_r == GTC_TRG_ARMED && trig_edge)
         trg_nxt = GTC_TRG_RUN;
      else if (hit)
         trg_nxt = GTC_TRG_ARMED;

      // Bus: take address and data in either order
      if (S_AXI_AWVALID && awrdy_r)
      begin
         awg_nxt = 1'b1;
         wa_nxt = S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && wrdy_r)
      begin
         wg_nxt = 1'b1;
         wd_nxt = S_AXI_WDATA;
         ws_nxt = S_AXI_WSTRB;
      end
      do_wr = awg_nxt && wg_nxt && !bval_r;
      if (bval_r && S_AXI_BREADY)
         bval_nxt = 1'b0;
      if (do_wr)
      begin
         wr_ok = 1'b1;
         case (wa_nxt[3:0])
            `GTC_OFF_CTRL:
            begin
               // Merge in full width first; only the low control bits exist
               ctrl_w = merge16({6'h00, ctrl_r}, wd_nxt, ws_nxt);
               ctrl_nxt = ctrl_w[`GTC_CTRL_W-1:0];
               // A fresh enable restarts prescaler, state and output level
               if (!en && ctrl_nxt[`GTC_CTRL_EN])
               begin
                  presc_nxt = 7'h00;
                  trg_nxt = GTC_TRG_ARMED;
                  out_nxt = ctrl_nxt[`GTC_CTRL_POL];
               end
            end
            `GTC_OFF_COUNT:  cnt_nxt = merge16(cnt_r, wd_nxt, ws_nxt);
            `GTC_OFF_RELOAD: rld_nxt = merge16(rld_r, wd_nxt, ws_nxt);
            `GTC_OFF_STATUS: wr_ok = 1'b1;
            default:         wr_ok = 1'b0;
         endcase
         awg_nxt = 1'b0;
         wg_nxt = 1'b0;
         bval_nxt = 1'b1;
         bresp_nxt = wr_ok ? `GTC_RESP_OKAY : `GTC_RESP_SLVERR;
      end
      // Ready drops while a word is held or a response waits
      awrdy_nxt = !awg_nxt && !bval_nxt;
      wrdy_nxt = !wg_nxt && !bval_nxt;

      // Read: one outstanding, data captured at the address handshake
      if (rval_r && S_AXI_RREADY)
         rval_nxt = 1'b0;
      if (S_AXI_ARVALID && arrdy_r)
      begin
         rval_nxt = 1'b1;
         rresp_nxt = `GTC_RESP_OKAY;
         case (S_AXI_ARADDR[3:0])
            `GTC_OFF_CTRL:   rdat_nxt = {22'h000000, ctrl_r};
            `GTC_OFF_COUNT:  rdat_nxt = {16'h0000, cnt_r};
            `GTC_OFF_RELOAD: rdat_nxt = {16'h0000, rld_r};
            `GTC_OFF_STATUS: rdat_nxt = {29'h00000000, trg_r == GTC_TRG_ARMED && en &&
                                         mode == GTC_TRIG_SHOT, out_r, timed || edge_mode};
            default:
            begin
               rdat_nxt = 32'h00000000;
               rresp_nxt = `GTC_RESP_SLVERR;
            end
         endcase
      end
      arrdy_nxt = !rval_nxt;
   end

   // ----------------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------------
   always_ff @(posedge CORE_CLK or posedge RESET)
   begin
      if (RESET)
      begin
         ctrl_r <= `GTC_CTRL_RST;
         cnt_r <= `GTC_COUNT_RST;
         rld_r <= `GTC_RELOAD_RST;
         presc_r <= 7'h00;
         trg_r <= GTC_TRG_ARMED;
         out_r <= 1'b0;
         irq_r <= 1'b0;
         awg_r <= 1'b0;
         wg_r <= 1'b0;
         wa_r <= '0;
         wd_r <= 32'h00000000;
         ws_r <= 4'h0;
         awrdy_r <= 1'b0;
         wrdy_r <= 1'b0;
         bval_r <= 1'b0;
         bresp_r <= 2'h0;
         arrdy_r <= 1'b0;
         rval_r <= 1'b0;
         rdat_r <= 32'h00000000;
         rresp_r <= 2'h0;
      end
      else
      begin
         ctrl_r <= ctrl_nxt;
         cnt_r <= cnt_nxt;
         rld_r <= rld_nxt;
         presc_r <= presc_nxt;
         trg_r <= trg_nxt;
         out_r <= out_nxt;
         irq_r <= irq_nxt;
         awg_r <= awg_nxt;
         wg_r <= wg_nxt;
         wa_r <= wa_nxt;
         wd_r <= wd_nxt;
         ws_r <= ws_nxt;
         awrdy_r <= awrdy_nxt;
         wrdy_r <= wrdy_nxt;
         bval_r <= bval_nxt;
         bresp_r <= bresp_nxt;
         arrdy_r <= arrdy_nxt;
         rval_r <= rval_nxt;
         rdat_r <= rdat_nxt;
         rresp_r <= rresp_nxt;
      end
   end

   // Outputs straight from flip-flops
   assign S_AXI_AWREADY = awrdy_r;
   assign S_AXI_WREADY  = wrdy_r;
   assign S_AXI_BVALID  = bval_r;
   assign S_AXI_BRESP   = bresp_r;
   assign S_AXI_ARREADY = arrdy_r;
   assign S_AXI_RVALID  = rval_r;
   assign S_AXI_RDATA   = rdat_r;
   assign S_AXI_RRESP   = rresp_r;
   assign TIMER_OUT     = out_r;
   assign TIMER_OUT_EN  = ctrl_r[`GTC_CTRL_OEN];
   assign TIMER_IRQ     = irq_r;

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (RESET);

   sequence s_pulse_back;
      (out_r != $past(out_r)) ##1 (out_r == $past(pol));
   endsequence

   one_shot_stop_a: assert property (hit && mode == GTC_ONE_SHOT && !wr_land
      |=> !en && cnt_r == 16'h0001 && TIMER_IRQ) else $error("one-shot did not stop");
   shot_pulse_a: assert property (hit && shot_mode && !wr_land
      |=> s_pulse_back) else $error("one-shot pulse not one cycle");
   trig_armed_a: assert property (en && mode == GTC_TRIG_SHOT && trg_r == GTC_TRG_ARMED
      && !wr_land |=> $stable(cnt_r)) else $error("armed timer counted");
   trig_ignore_a: assert property (trg_r == GTC_TRG_RUN && trig_edge && !hit && !wr_land
      |=> trg_r == GTC_TRG_RUN) else $error("trigger during count not ignored");
   cont_keep_a: assert property (hit && mode == GTC_CONT && !wr_land
      |=> en && cnt_r == 16'h0001 && out_r != $past(out_r))
      else $error("continuous reload wrong");
   presc_div_a: assert property (tick && ctrl_r[`GTC_CTRL_PS_HI:`GTC_CTRL_PS_LO] == 3'h7
      |-> presc_r == 7'h7F) else $error("prescaler terminal wrong");
   count_wrap_a: assert property (step && !hit && cnt_r == 16'hFFFF && !wr_land
      |=> cnt_r == 16'h0000) else $error("count did not roll over");
   edge_count_a: assert property (edge_mode && !step && !wr_land
      |=> $stable(cnt_r)) else $error("counter mode counted without edge");
   trig_start_a: assert property (en && mode == GTC_TRIG_SHOT && trg_r == GTC_TRG_ARMED
      && $rose(TIMER_IN) && !pol && !wr_land ##1 !wr_land
      |-> ##[1:2] trg_r == GTC_TRG_RUN) else $error("trigger latency wrong");

endmodule : gtc_timer

//--- tb/gtc_pin_model.sv
/* Partner: drives the timer input pin and the comparator output.
   Assumes the bench calls pulse() from its own process. */
`timescale 1ns/1ps
module gtc_pin_model
(
   // Clock
   input  wire logic clk,
   // Lines into the timer
   output logic      tin,
   output logic      cmp
);
   // Both lines idle low
   initial
   begin
      tin = 1'b0;
      cmp = 1'b0;
   end
   // One rise then one fall; four clocks a period keeps to a quarter clock
   task automatic pulse(input bit sel, input int n);
      repeat (n)
      begin
         repeat (2) @(posedge clk);
         if (sel) cmp <= 1'b1; else tin <= 1'b1;
         repeat (2) @(posedge clk);
         if (sel) cmp <= 1'b0; else tin <= 1'b0;
      end
   endtask : pulse
endmodule : gtc_pin_model

//--- tb/general_timer_count_modes_tb.sv
/* Self-checking bench of the timer: bus tasks, timed and edge modes.
   Assumes the pin partner model and the register header. */
`timescale 1ns/1ps
`include "gtc_regs.svh"
module general_timer_count_modes_tb;
   import gtc_pkg::*;
   // ---------------- Signals ----------------
   logic clk, rst, awv, wv, bre, arv, rre, tin, cmp;
   logic [3:0]  awa, ara;
   logic [31:0] wd, rdat;
   logic [1:0]  rsp;
   wire  logic  awr, wr_, bv, arr, rv, tout, toen, irq;
   wire  logic [1:0]  br, rr;
   wire  logic [31:0] rd_;
   int n_fail, checked, d, r, s, e, o, m, k;
   logic [31:0] seed = 32'h14;
   gtc_timer dut (.CORE_CLK(clk), .RESET(rst), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
      .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv),
      .S_AXI_WREADY(wr_), .S_AXI_BRESP(br), .S_AXI_BVALID(bv), .S_AXI_BREADY(bre),
      .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rd_),
      .S_AXI_RRESP(rr), .S_AXI_RVALID(rv), .S_AXI_RREADY(rre), .TIMER_IN(tin),
      .COMP_IN(cmp), .TIMER_OUT(tout), .TIMER_OUT_EN(toen), .TIMER_IRQ(irq));
   gtc_pin_model pins (.clk(clk), .tin(tin), .cmp(cmp));
   // 100 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // ---------------- Helpers ----------------
   function automatic int xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return int'(seed[15:0]);
   endfunction : xs
   // Control word: output function always on
   function automatic logic [31:0] ctl(int md, int ps, int pl, int en);
      return {22'h0, 1'b1, pl[0], ps[2:0], md[3:0], en[0]};
   endfunction : ctl
   task automatic chk(input bit ok, input string msg);
      checked++;
      if (!ok)
      begin
         n_fail++;
         $display("unexpected at %0t: %s", $time, msg);
      end
   endtask : chk
   task automatic give_verdict();
      $display("checks %0d, mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : give_verdict
   // Write: hold each channel until taken, then wait for the answer
   task automatic wr(input logic [3:0] a, input logic [31:0] v);
      bit ta, tw;
      @(posedge clk);
      {awa, wd, awv, wv, bre} <= {a, v, 3'b111};
      {ta, tw} = 2'b00;
      for (int i = 0; i < 50; i++)
      begin
         @(posedge clk);
         if (bv === 1'b1 && ta && tw)
         begin
            rsp = br;
            bre <= 1'b0;
            return;
         end
         if (awr === 1'b1 && !ta)
         begin
            ta = 1'b1;
            awv <= 1'b0;
         end
         if (wr_ === 1'b1 && !tw)
         begin
            tw = 1'b1;
            wv <= 1'b0;
         end
      end
      chk(0, "write hung");
      give_verdict();
   endtask : wr
   task automatic rd(input logic [3:0] a);
      bit ta;
      @(posedge clk);
      {ara, arv, rre} <= {a, 2'b11};
      ta = 1'b0;
      for (int i = 0; i < 50; i++)
      begin
         @(posedge clk);
         if (rv === 1'b1 && ta)
         begin
            {rdat, rsp} = {rd_, rr};
            rre <= 1'b0;
            return;
         end
         if (arr === 1'b1 && !ta)
         begin
            ta = 1'b1;
            arv <= 1'b0;
         end
      end
      chk(0, "read hung");
      give_verdict();
   endtask : rd
   // Edges until an interrupt pulse; -1 when none within the bound
   task automatic wait_irq(input int lim, output int n);
      for (n = 1; n <= lim; n++)
      begin
         @(posedge clk);
         if (irq === 1'b1) return;
      end
      n = -1;
   endtask : wait_irq
   task automatic setup(input int md, ps, pl, st, rl);
      wr(`GTC_OFF_CTRL, ctl(md, ps, pl, 0));
      wr(`GTC_OFF_COUNT, st);
      wr(`GTC_OFF_RELOAD, rl);
      wr(`GTC_OFF_CTRL, ctl(md, ps, pl, 1));
   endtask : setup
   // ---------------- Main sequence ----------------
   initial
   begin
      {rst, awv, wv, bre, arv, rre, awa, ara, wd, n_fail, checked} = '0;
      rst = 1'b1;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      chk(toen === 1'b0 && irq === 1'b0, "pins after reset");
      rd(`GTC_OFF_COUNT);
      chk(rdat === 32'h0000_0001, "count reset");
      rd(4'h6);
      chk(rsp === `GTC_RESP_SLVERR, "unmapped read");
      wr(`GTC_OFF_STATUS, 32'h0000_FFFF);
      chk(rsp === `GTC_RESP_OKAY, "status write");
      // One-shot over every prescale exponent
      for (e = 0; e < 8; e++)
      begin
         {r, s, o} = {2 + xs() % 6, 1 + xs() % 2, xs() % 2};
         setup(GTC_ONE_SHOT, e, o, s, r);
         wait_irq(2000, d);
         chk(d === ((r - s + 1) << e), "one-shot timeout");
         chk(tout === ~o[0], "one-shot pulse");
         chk(toen === 1'b1, "output enable");
         @(posedge clk);
         chk(tout === o[0], "one-shot pulse width");
         rd(`GTC_OFF_CTRL);
         chk(rdat[0] === 1'b0, "one-shot self disable");
         rd(`GTC_OFF_COUNT);
         chk(rdat === 32'h0000_0001, "one-shot restart value");
         wait_irq(300, d);
         chk(d === -1, "one-shot stopped");
      end
      // Polarity inverted after start leaves the output at the new level
      setup(GTC_ONE_SHOT, 3, 0, 1, 10);
      wr(`GTC_OFF_CTRL, ctl(GTC_ONE_SHOT, 3, 1, 1));
      wait_irq(200, d);
      @(posedge clk);
      chk(d > 0 && tout === 1'b1, "lasting output change");
      // Continuous: first pass from the start count, then full periods
      {e, r} = {xs() % 3, 3 + xs() % 5};
      setup(GTC_CONT, e, 0, 2, r);
      wait_irq(500, d);
      chk(d === ((r - 1) << e), "first pass");
      o = tout;
      wait_irq(500, d);
      chk(d === (r << e), "continuous period");
      chk(tout === ~o[0], "continuous toggle");
      // Start above reload: count must wrap through 0000h first
      setup(GTC_CONT, 0, 0, 32'h0000_FFFE, 3);
      wait_irq(20, d);
      chk(d === 'h1_0000 - 'hFFFE + 3 + 1, "count rollover");
      // Triggered one-shot: armed, latency, ignored edges, re-arm
      setup(GTC_TRIG_SHOT, 0, 0, 1, 12);
      wait_irq(40, d);
      chk(d === -1, "armed without trigger");
      fork
         pins.pulse(0, 3);
         wait_irq(40, d);
      join
      chk(d >= 17 && d <= 19, "trigger latency");
      chk(tout === 1'b1, "trigger pulse level");
      wait_irq(40, d);
      chk(d === -1, "edges while running");
      fork
         pins.pulse(0, 1);
         wait_irq(40, d);
      join
      chk(d > 0, "re-armed");
      // Edge counters; prescale at its maximum must not matter
      for (m = GTC_COUNTER; m <= GTC_COMP_CNT; m++)
      begin
         {k, o} = {2 + xs() % 4, xs() % 2};
         setup(m, 7, o, 1, k);
         fork
            pins.pulse(m == GTC_COMP_CNT, k - 1);
            wait_irq(4 * k + 4, d);
         join
         chk(d === -1, "early count event");
         e = tout;
         fork
            pins.pulse(m == GTC_COMP_CNT, 1);
            wait_irq(12, d);
         join
         chk(d > 0, "count reached");
         chk(tout === ~e[0], "counter toggle");
      end
      give_verdict();
   end
endmodule : general_timer_count_modes_tb
